/* chgds_pkg.sv */
// package of constants and types for the charger detail status registers
//
// Function
// - code 0x00 in prequalification, charger good set
// - 0x01 fast constant current, 0x02 constant voltage
// - 0x03 top-off good, 0x04 top-off not good
// - 0x06 timer fault, 0x07 detect-input suspend
// - 0x08 charger off, charger good set
// - 0x0a thermal shutdown; reserved codes never produced
// - battery code 0x00 when no battery present
// - battery 0x01 below prequal, with state 0x00
// - battery 0x02 timer fault, with state 0x06
// - 0x03 healthy above sysmin, 0x04 below sysmin
// - battery 0x05 overvoltage, held 37.5 ms
// - overvoltage only with valid input or boost
// - 0x06 after 6 ms overcurrent; read clears
// - fault priority: overcurrent, nobattery, overvoltage, timer, prequal
// - bit 7 follows junction over regulation threshold
// - bypass bits: reverse boost, boost, buck negative
// - bypass good exactly when bypass bits zero
// - battery good exactly for codes 0x03, 0x04
`default_nettype none

package chgds_pkg;

    // =====================================================================
    // register map
    localparam logic [7:0] CHGDS_ADDR_CHG_BAT = 8'hb4; // charger_battery_detail_status
    localparam logic [7:0] CHGDS_ADDR_BYPASS  = 8'hb5; // bypass_node_detail_status
    localparam logic [7:0] CHGDS_RESET_VALUE  = 8'h00;
    localparam logic [7:0] CHGDS_UNMAPPED     = 8'h00;

    // =====================================================================
    // field positions
    localparam int CHGDS_CS_LSB   = 0; // charge_state_code 3:0
    localparam int CHGDS_CS_MSB   = 3;
    localparam int CHGDS_BC_LSB   = 4; // battery_condition_code 6:4
    localparam int CHGDS_BC_MSB   = 6;
    localparam int CHGDS_THERMAL_REGULATION_FLAG_BIT = 7; // thermal_regulation_flag
    localparam int CHGDS_BYP_W    = 3; // bypass_fault_bits 2:0, bit 3 reads zero

    // =====================================================================
    // charge state codes
    localparam logic [3:0] CHGDS_CS_PREQUAL   = 4'h0;
    localparam logic [3:0] CHGDS_CS_FAST_CC   = 4'h1;
    localparam logic [3:0] CHGDS_CS_FAST_CV   = 4'h2;
    localparam logic [3:0] CHGDS_CS_TOPOFF    = 4'h3;
    localparam logic [3:0] CHGDS_CS_TOPOFF_NG = 4'h4;
    localparam logic [3:0] CHGDS_CS_TIMER     = 4'h6;
    localparam logic [3:0] CHGDS_CS_DETECT    = 4'h7;
    localparam logic [3:0] CHGDS_CS_OFF       = 4'h8;
    localparam logic [3:0] CHGDS_CS_THERMAL   = 4'ha;

    // =====================================================================
    // battery condition codes
    localparam logic [2:0] CHGDS_BC_NO_BAT  = 3'h0;
    localparam logic [2:0] CHGDS_BC_PREQUAL = 3'h1;
    localparam logic [2:0] CHGDS_BC_TIMER   = 3'h2;
    localparam logic [2:0] CHGDS_BC_OK_HIGH = 3'h3;
    localparam logic [2:0] CHGDS_BC_OK_LOW  = 3'h4;
    localparam logic [2:0] CHGDS_BC_OVP     = 3'h5;
    localparam logic [2:0] CHGDS_BC_OC      = 3'h6;

    // =====================================================================
    // timing
    localparam longint CHGDS_CLK_HZ      = 50_000_000;
    localparam longint CHGDS_OVP_HOLD_US = 37_500; // 37.5 ms
    localparam longint CHGDS_OC_MIN_US   = 6_000;  // 6 ms
    localparam int     CHGDS_CNT_W       = 21;
    localparam longint CHGDS_OVP_HOLD_CYC =
        (CHGDS_OVP_HOLD_US * CHGDS_CLK_HZ + 999_999) / 1_000_000;
    localparam longint CHGDS_OC_MIN_CYC =
        (CHGDS_OC_MIN_US * CHGDS_CLK_HZ + 999_999) / 1_000_000;

    // =====================================================================
    // phases reported by the charger core state machine
    typedef enum logic [3:0] {
        CHGDS_PH_PREQUAL,
        CHGDS_PH_FAST_CC,
        CHGDS_PH_FAST_CV,
        CHGDS_PH_TOPOFF,
        CHGDS_PH_TOPOFF_DONE,
        CHGDS_PH_TIMER_FAULT,
        CHGDS_PH_DETECT_SUSPEND,
        CHGDS_PH_OFF,
        CHGDS_PH_THERMAL_OFF
    } chgds_phase_t;

endpackage : chgds_pkg

`default_nettype wire

/* chgds_status_regs.sv */
// charger detail status registers: code encoding, fault hold timers, register read port
`timescale 1ns/1ps
`default_nettype none

module chgds_status_regs #(
    parameter logic [20:0] OVP_HOLD_CYC = 21'(chgds_pkg::CHGDS_OVP_HOLD_CYC),
    parameter logic [20:0] OC_MIN_CYC   = 21'(chgds_pkg::CHGDS_OC_MIN_CYC)
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    // charger core status
    input  wire chgds_pkg::chgds_phase_t chg_phase_i,
    input  wire logic                   no_battery_i,
    input  wire logic                   below_prequal_i,
    input  wire logic                   timer_fault_i,
    input  wire logic                   above_sysmin_i,
    input  wire logic                   overvoltage_cmp_i,
    input  wire logic                   input_valid_i,
    input  wire logic                   boost_mode_i,
    input  wire logic                   overcurrent_i,
    input  wire logic                   tj_over_threshold_i,
    input  wire logic [2:0]             bypass_fault_bits_i,
    // register port from the serial interface engine
    input  wire logic [7:0]             reg_addr_i,
    input  wire logic                   reg_rd_i,
    input  wire logic                   reg_wr_i,
    input  wire logic [7:0]             reg_wdata_i,
    output logic      [7:0]             reg_rdata_o,
    output logic                        reg_ack_o,
    // summaries and event
    output logic                        charger_good_flag_o,
    output logic                        battery_good_flag_o,
    output logic                        bypass_good_flag_o,
    output logic                        bypass_change_interrupt_o
);

    // =====================================================================
    // state
    logic [3:0]  cs_code_q;
    logic [3:0]  cs_code_d;
    logic        chg_good_d;
    logic [2:0]  bc_code_q;
    logic [2:0]  bc_code_d;
    logic        thermal_regulation_flag_q;
    logic [2:0]  byp_q;
    logic [20:0] ovp_cnt_q;
    logic [20:0] ovp_cnt_d;
    logic [20:0] oc_cnt_q;
    logic [20:0] oc_cnt_d;
    logic        oc_hold_q;
    logic        oc_hold_d;
    logic [7:0]  rdata_q;
    logic        ack_q;
    logic        chg_good_q;
    logic        bat_good_q;
    logic        byp_good_q;
    logic        byp_intr_q;

    // =====================================================================
    // charge state encoding from the core phase
    always_comb begin
        cs_code_d  = chgds_pkg::CHGDS_CS_OFF;
        chg_good_d = 1'b1;
        case (chg_phase_i)
            chgds_pkg::CHGDS_PH_PREQUAL: begin
                cs_code_d  = chgds_pkg::CHGDS_CS_PREQUAL;
                chg_good_d = 1'b1;
            end
            chgds_pkg::CHGDS_PH_FAST_CC: begin
                cs_code_d  = chgds_pkg::CHGDS_CS_FAST_CC;
                chg_good_d = 1'b1;
            end
            chgds_pkg::CHGDS_PH_FAST_CV: begin
                cs_code_d  = chgds_pkg::CHGDS_CS_FAST_CV;
                chg_good_d = 1'b1;
            end
            chgds_pkg::CHGDS_PH_TOPOFF: begin
                cs_code_d  = chgds_pkg::CHGDS_CS_TOPOFF;
                chg_good_d = 1'b1;
            end
            chgds_pkg::CHGDS_PH_TOPOFF_DONE: begin
                cs_code_d  = chgds_pkg::CHGDS_CS_TOPOFF_NG;
                chg_good_d = 1'b0;
            end
            chgds_pkg::CHGDS_PH_TIMER_FAULT: begin
                cs_code_d  = chgds_pkg::CHGDS_CS_TIMER;
                chg_good_d = 1'b0;
            end
            chgds_pkg::CHGDS_PH_DETECT_SUSPEND: begin
                cs_code_d  = chgds_pkg::CHGDS_CS_DETECT;
                chg_good_d = 1'b0;
            end
            chgds_pkg::CHGDS_PH_THERMAL_OFF: begin
                cs_code_d  = chgds_pkg::CHGDS_CS_THERMAL;
                chg_good_d = 1'b0;
            end
            default: begin
                cs_code_d  = chgds_pkg::CHGDS_CS_OFF;
                chg_good_d = 1'b1;
            end
        endcase
    end

    // =====================================================================
    // overvoltage qualify and hold timer
    wire ovp_active = overvoltage_cmp_i & (input_valid_i | boost_mode_i);
    wire ovp_flag   = ovp_active | (ovp_cnt_q != 21'h0);
    assign ovp_cnt_d = ovp_active ? OVP_HOLD_CYC :
                       (ovp_cnt_q != 21'h0) ? ovp_cnt_q - 21'h1 : 21'h0;

    // overcurrent duration counter and sticky hold, set wins over read clear
    wire oc_done   = overcurrent_i & (oc_cnt_q == OC_MIN_CYC - 21'h1);
    wire rd_chgbat = reg_rd_i & (reg_addr_i == chgds_pkg::CHGDS_ADDR_CHG_BAT);
    assign oc_cnt_d  = !overcurrent_i ? 21'h0 :
                       (oc_cnt_q == OC_MIN_CYC - 21'h1) ? oc_cnt_q : oc_cnt_q + 21'h1;
    assign oc_hold_d = oc_done | (oc_hold_q & ~rd_chgbat);

    // =====================================================================
    // battery condition priority encoder
    assign bc_code_d = oc_hold_q       ? chgds_pkg::CHGDS_BC_OC :
                       no_battery_i    ? chgds_pkg::CHGDS_BC_NO_BAT :
                       ovp_flag        ? chgds_pkg::CHGDS_BC_OVP :
                       timer_fault_i   ? chgds_pkg::CHGDS_BC_TIMER :
                       below_prequal_i ? chgds_pkg::CHGDS_BC_PREQUAL :
                       above_sysmin_i  ? chgds_pkg::CHGDS_BC_OK_HIGH :
                                         chgds_pkg::CHGDS_BC_OK_LOW;

    // register images; writes never reach them
    wire [7:0] img_chgbat = {thermal_regulation_flag_q, bc_code_q, cs_code_q};
    wire [7:0] img_bypass = {5'h00, byp_q};
    wire       hit_chgbat = reg_addr_i == chgds_pkg::CHGDS_ADDR_CHG_BAT;
    wire       hit_bypass = reg_addr_i == chgds_pkg::CHGDS_ADDR_BYPASS;
    wire [7:0] rd_mux     = hit_chgbat ? img_chgbat :
                            hit_bypass ? img_bypass : chgds_pkg::CHGDS_UNMAPPED;
    wire       unused_wr  = reg_wr_i ^ (^reg_wdata_i);

    // =====================================================================
    // status capture
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_code_q <= 4'h0;
            bc_code_q <= 3'h0;
            thermal_regulation_flag_q    <= 1'b0;
            byp_q     <= 3'h0;
        end else begin
            cs_code_q <= cs_code_d;
            bc_code_q <= bc_code_d;
            thermal_regulation_flag_q    <= tj_over_threshold_i;
            byp_q     <= bypass_fault_bits_i;
        end
    end

    // timers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ovp_cnt_q <= 21'h0;
            oc_cnt_q  <= 21'h0;
            oc_hold_q <= 1'b0;
        end else begin
            ovp_cnt_q <= ovp_cnt_d;
            oc_cnt_q  <= oc_cnt_d;
            oc_hold_q <= oc_hold_d;
        end
    end

    // read port, summaries and bypass change event
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q    <= chgds_pkg::CHGDS_RESET_VALUE;
            ack_q      <= 1'b0;
            chg_good_q <= 1'b0;
            bat_good_q <= 1'b0;
            byp_good_q <= 1'b0;
            byp_intr_q <= 1'b0;
        end else begin
            rdata_q    <= reg_rd_i ? rd_mux : rdata_q;
            ack_q      <= reg_rd_i | reg_wr_i;
            chg_good_q <= chg_good_d;
            bat_good_q <= (bc_code_d == chgds_pkg::CHGDS_BC_OK_HIGH) |
                          (bc_code_d == chgds_pkg::CHGDS_BC_OK_LOW);
            byp_good_q <= bypass_fault_bits_i == 3'h0;
            byp_intr_q <= bypass_fault_bits_i != byp_q;
        end
    end

    assign reg_rdata_o               = rdata_q;
    assign reg_ack_o                 = ack_q;
    assign charger_good_flag_o       = chg_good_q;
    assign battery_good_flag_o       = bat_good_q;
    assign bypass_good_flag_o        = byp_good_q;
    assign bypass_change_interrupt_o = byp_intr_q;

    // =====================================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_prequal;
        chg_phase_i == chgds_pkg::CHGDS_PH_PREQUAL |=> cs_code_q == 4'h0 && chg_good_q;
    endproperty
    a_prequal: assert property (p_prequal) else $error("prequal code wrong");

    property p_fast;
        chg_phase_i == chgds_pkg::CHGDS_PH_FAST_CV |=> cs_code_q == 4'h2 && chg_good_q;
    endproperty
    a_fast: assert property (p_fast) else $error("fast cv code wrong");

    property p_topoff_done;
        chg_phase_i == chgds_pkg::CHGDS_PH_TOPOFF_DONE |=> cs_code_q == 4'h4 && !chg_good_q;
    endproperty
    a_topoff_done: assert property (p_topoff_done) else $error("top-off code wrong");

    property p_timer;
        chg_phase_i == chgds_pkg::CHGDS_PH_TIMER_FAULT |=> cs_code_q == 4'h6 && !chg_good_q;
    endproperty
    a_timer: assert property (p_timer) else $error("timer fault code wrong");

    property p_off;
        chg_phase_i == chgds_pkg::CHGDS_PH_OFF |=> cs_code_q == 4'h8 && chg_good_q;
    endproperty
    a_off: assert property (p_off) else $error("off code wrong");

    property p_reserved;
        cs_code_q != 4'h9 && cs_code_q < 4'hc;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved state code");

    property p_ovp_hold;
        $fell(ovp_active) && !oc_hold_q && !no_battery_i ##1 !oc_hold_q && !no_battery_i
            |=> bc_code_q == 3'h5;
    endproperty
    a_ovp_hold: assert property (p_ovp_hold) else $error("overvoltage not held");

    property p_ovp_gate;
        ovp_cnt_q == 21'h0 && !(input_valid_i | boost_mode_i) |=> bc_code_q != 3'h5;
    endproperty
    a_ovp_gate: assert property (p_ovp_gate) else $error("ungated overvoltage");

    property p_oc_priority;
        oc_hold_q |=> bc_code_q == 3'h6;
    endproperty
    a_oc_priority: assert property (p_oc_priority) else $error("overcurrent not first");

    property p_oc_clear;
        rd_chgbat && !oc_done |=> !oc_hold_q;
    endproperty
    a_oc_clear: assert property (p_oc_clear) else $error("read did not clear");

    property p_thermal_regulation_flag;
        tj_over_threshold_i |=> img_chgbat[7];
    endproperty
    a_thermal_regulation_flag: assert property (p_thermal_regulation_flag) else $error("thermal flag missing");

    property p_byp_intr;
        $changed(byp_q) |-> bypass_change_interrupt_o; // pulse stands with the new image
    endproperty
    a_byp_intr: assert property (p_byp_intr) else $error("bypass change missed");

    property p_byp_good;
        rst_n_i |=> bypass_good_flag_o == (byp_q == 3'h0); // skips the reset-release edge
    endproperty
    a_byp_good: assert property (p_byp_good) else $error("bypass good wrong");

    property p_bat_good;
        ##1 battery_good_flag_o == (bc_code_q == 3'h3 || bc_code_q == 3'h4);
    endproperty
    a_bat_good: assert property (p_bat_good) else $error("battery good wrong");

    property p_read;
        reg_rd_i && hit_chgbat |=> reg_rdata_o == $past(img_chgbat) && reg_ack_o;
    endproperty
    a_read: assert property (p_read) else $error("read data wrong");

    property p_thermal_off;
        chg_phase_i == chgds_pkg::CHGDS_PH_THERMAL_OFF |=> cs_code_q == 4'ha && !chg_good_q;
    endproperty
    a_thermal_off: assert property (p_thermal_off) else $error("thermal code wrong");

    property p_no_bat;
        no_battery_i && !oc_hold_q |=> bc_code_q == 3'h0;
    endproperty
    a_no_bat: assert property (p_no_bat) else $error("no battery code wrong");

    property p_prequal_bc;
        below_prequal_i && !timer_fault_i && !ovp_flag && !no_battery_i && !oc_hold_q
            |=> bc_code_q == 3'h1;
    endproperty
    a_prequal_bc: assert property (p_prequal_bc) else $error("prequal battery code wrong");

    property p_byp_img;
        rst_n_i |=> img_bypass == {5'h00, $past(bypass_fault_bits_i)};
    endproperty
    a_byp_img: assert property (p_byp_img) else $error("bypass image wrong");

    // a write is acknowledged and leaves the read data untouched
    property p_wr_ignored;
        reg_wr_i && !reg_rd_i |=> reg_ack_o && $stable(reg_rdata_o);
    endproperty
    a_wr_ignored: assert property (p_wr_ignored) else $error("write not ignored");

    c_ovp: cover property (ovp_active ##1 !ovp_active ##1 bc_code_q == 3'h5);
    c_oc:  cover property (oc_done ##1 oc_hold_q ##1 rd_chgbat);
    c_byp: cover property (bypass_change_interrupt_o ##1 !bypass_good_flag_o);
    c_set_clear: cover property (oc_done && rd_chgbat);

endmodule : chgds_status_regs

`default_nettype wire

/* chgds_host_model.sv */
// host side model that reads and writes the byte register port of the status block
`timescale 1ns/1ps
`default_nettype none

module chgds_host_model (
    input  wire logic       clk_i,
    output logic      [7:0] reg_addr_o,
    output logic            reg_rd_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_ack_i
);
    // =====================================================================
    // idle bus values from time zero
    initial begin
        reg_addr_o  = 8'h00;
        reg_rd_o    = 1'b0;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
    end

    // =====================================================================
    // one strobe cycle, then a bounded wait for the acknowledge
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                          output logic [7:0] rd, output logic ok);
        int n;
        n = 0;
        @(posedge clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= wd;
        reg_rd_o    <= !wr;
        reg_wr_o    <= wr;
        @(posedge clk_i);
        reg_rd_o    <= 1'b0;
        reg_wr_o    <= 1'b0;
        reg_addr_o  <= ~a; // released address shows a different value
        reg_wdata_o <= ~wd;
        // answer is taken at the rising edge where ack is sampled high
        @(posedge clk_i);
        while (reg_ack_i !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            n++;
        end
        ok = (reg_ack_i === 1'b1) && (n == 0); // ack must come in the next cycle
        rd = reg_rdata_i;
    endtask : access
endmodule : chgds_host_model

`default_nettype wire

/* charger_detail_status_regs_tb.sv */
// self-checking bench for the charger detail status registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end

module charger_detail_status_regs_tb;
    // =====================================================================
    // signals and design instance
    localparam logic [20:0] OVP = 21'h14; // shortened overvoltage hold
    localparam logic [20:0] OCM = 21'h5;  // shortened overcurrent qualify
    logic                     clk, rst_n, nob, pq, tmr, sym, ovc, ivld, bst, oc, tj;
    chgds_pkg::chgds_phase_t  phase;
    logic [2:0]               byp;
    logic [7:0]               addr, wdata, rdata, d;
    logic                     rd, wr, ack, chg_good, bat_good, byp_good, irq, ok;
    int                       n_errors, checks;
    logic [3:0]               cs_tab[9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'ha};
    logic [8:0]               cg_tab = 9'h08f;
    logic [4:0]               bv_tab[6] = '{5'h00, 5'h02, 5'h0a, 5'h0e, 5'h07, 5'h17};
    logic [2:0]               be_tab[6] = '{3'h4, 3'h3, 3'h1, 3'h2, 3'h5, 3'h0};
    logic [2:0]               byp_tab[5] = '{3'h1, 3'h2, 3'h4, 3'h7, 3'h0};

    chgds_status_regs #(.OVP_HOLD_CYC(OVP), .OC_MIN_CYC(OCM)) dut_u (
        .clk_i(clk), .rst_n_i(rst_n), .chg_phase_i(phase), .no_battery_i(nob),
        .below_prequal_i(pq), .timer_fault_i(tmr), .above_sysmin_i(sym),
        .overvoltage_cmp_i(ovc), .input_valid_i(ivld), .boost_mode_i(bst),
        .overcurrent_i(oc), .tj_over_threshold_i(tj), .bypass_fault_bits_i(byp),
        .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .reg_ack_o(ack), .charger_good_flag_o(chg_good),
        .battery_good_flag_o(bat_good), .bypass_good_flag_o(byp_good),
        .bypass_change_interrupt_o(irq));

    chgds_host_model host_u (
        .clk_i(clk), .reg_addr_o(addr), .reg_rd_o(rd), .reg_wr_o(wr),
        .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_ack_i(ack));

    // =====================================================================
    // clock, verdict and helpers
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic report_and_stop();
        if (n_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // read a register and compare with the expected byte
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host_u.access(1'b0, a, 8'h00, d, ok);
        `CHK("ack", 1'b1, ok)
        `CHK("rdata", e, d)
    endtask : rd_chk

    // apply battery conditions {nob, pq, tmr, sym, ovc} and let them settle
    task automatic batt(input logic [4:0] v);
        @(posedge clk);
        {nob, pq, tmr, sym, ovc} <= v;
        @(posedge clk);
    endtask : batt

    // =====================================================================
    // watchdog sized well above the expected run of about 260 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end

    // =====================================================================
    // test sequence
    initial begin
        n_errors = 0;
        checks = 0;
        rst_n = 1'b0;
        phase = chgds_pkg::CHGDS_PH_FAST_CC;
        {nob, pq, tmr, sym, ovc, ivld, bst, oc, tj} = 9'h028; // healthy battery, valid input
        byp = 3'h0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        `CHK("reset rdata", 8'h00, rdata)
        @(posedge clk);
        rst_n <= 1'b1;
        // every charge phase with its code and charger good flag
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            phase <= chgds_pkg::chgds_phase_t'(i[3:0]);
            @(posedge clk);
            rd_chk(8'hb4, {1'b0, 3'h3, cs_tab[i]});
            `CHK("chg_good", cg_tab[i], chg_good)
        end
        // thermal regulation flag set and cleared
        tj <= 1'b1;
        rd_chk(8'hb4, 8'hba);
        tj <= 1'b0;
        rd_chk(8'hb4, 8'h3a);
        phase <= chgds_pkg::CHGDS_PH_FAST_CC;
        // battery codes and fault priority
        for (int i = 0; i < 6; i++) begin
            batt(bv_tab[i]);
            rd_chk(8'hb4, {1'b0, be_tab[i], 4'h1});
            `CHK("bat_good", be_tab[i] inside {3'h3, 3'h4}, bat_good)
        end
        batt(5'h02);
        repeat (40) @(posedge clk);
        // overvoltage gating and hold time
        ivld <= 1'b0;
        batt(5'h03);
        rd_chk(8'hb4, 8'h31);
        bst <= 1'b1;
        rd_chk(8'hb4, 8'h51);
        bst <= 1'b0;
        ivld <= 1'b1;
        batt(5'h02);
        repeat (5) @(posedge clk);
        rd_chk(8'hb4, 8'h51);
        repeat (40) @(posedge clk);
        rd_chk(8'hb4, 8'h31);
        // short overcurrent ignored, long one held until read
        oc <= 1'b1;
        repeat (3) @(posedge clk);
        oc <= 1'b0;
        rd_chk(8'hb4, 8'h31);
        oc <= 1'b1;
        repeat (10) @(posedge clk);
        oc <= 1'b0;
        batt(5'h12);
        rd_chk(8'hb4, 8'h61);
        rd_chk(8'hb4, 8'h01);
        batt(5'h02);
        // writes are ignored, unmapped address reads zero
        host_u.access(1'b1, 8'hb4, 8'hff, d, ok);
        `CHK("wr_ack_b4", 1'b1, ok)
        host_u.access(1'b1, 8'hb5, 8'hff, d, ok);
        `CHK("wr_ack_b5", 1'b1, ok)
        rd_chk(8'hb4, 8'h31);
        rd_chk(8'hb5, 8'h00);
        rd_chk(8'hb6, 8'h00);
        // bypass bits, change pulse and good summary
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            byp <= byp_tab[i];
            @(posedge clk);
            @(negedge clk);
            `CHK("byp_irq", 1'b1, irq)
            `CHK("byp_good", byp_tab[i] == 3'h0, byp_good)
            @(negedge clk);
            `CHK("byp_irq_end", 1'b0, irq)
            rd_chk(8'hb5, {5'h00, byp_tab[i]});
        end
        report_and_stop();
    end
endmodule : charger_detail_status_regs_tb

`default_nettype wire
